// file: core/fpeu_top.sv
// flash program/erase sequencer with key lock and avalon register slave
//
// Implementation choice: register access over Avalon-MM.
`timescale 1ns/1ps
module fpeu_top import fpeu_pkg::*; #(
  parameter int unsigned ERASE_CYCLES = 32'(ERASE_CYCLES_DFLT),
  parameter int unsigned PROG_CYCLES  = PROG_CYCLES_DFLT
) (
  // clock, reset, enable
  input  wire logic             mclk,
  input  wire logic             sys_rst,
  input  wire logic             clkEn,
  // avalon-mm slave
  input  wire logic [AV_AW-1:0] avs_address,
  input  wire logic             avs_read,
  input  wire logic             avs_write,
  input  wire logic [31:0]      avs_writedata,
  input  wire logic [3:0]       avs_byteenable,
  output logic [31:0]           avs_readdata,
  output logic                  avs_waitrequest,
  // flash macro
  output fpeu_cmd_s             flashCmd,
  output logic                  flashProgStrobe,
  output logic                  flashEraseStrobe,
  input  wire logic             flashMacroFail,
  // protection monitor
  input  wire logic             fetchUnprot,
  input  wire logic             accessProt,
  output logic                  chipResetReq,
  // interrupt
  output logic                  irq
);

  if (ERASE_CYCLES == 0 || PROG_CYCLES == 0) begin : g_bad_cycles
    $error("fpeu_top: operation cycle counts must be nonzero");
  end

  // bus state
  logic        waitReq_reg, waitReq_next;
  logic [31:0] rdData_reg,  rdData_next;

  // core state
  fpeu_key_e           key_reg,     key_next;
  fpeu_seq_e           seq_reg,     seq_next;
  logic                progSel_reg, progSel_next;
  logic                eraseSel_reg, eraseSel_next;
  logic                fail_reg,    fail_next;
  logic [FLASH_AW-1:0] tAddr_reg,   tAddr_next;
  fpeu_tgt_s           tgt_reg,     tgt_next;
  fpeu_cmd_s           cmd_reg,     cmd_next;
  logic                pStb_reg,    pStb_next;
  logic                eStb_reg,    eStb_next;
  logic                rstReq_reg,  rstReq_next;
  logic [EV_W-1:0]     stat_reg,    stat_next;
  logic [EV_W-1:0]     ien_reg,     ien_next;
  logic                irq_reg,     irq_next;

  logic [7:0]       idx;
  logic             wrAcc;
  logic             wrKey, wrCtrl, wrTaddr, wrTdata, wrIclr, wrIen;
  logic             tmrStart;
  logic [TMR_W-1:0] tmrLoad;
  logic             tmrDone;
  logic [EV_W-1:0]  ev;
  logic [7:0]       wd;

  assign idx     = avs_address[AV_AW-1:2];
  assign wd      = avs_writedata[7:0];
  assign wrAcc   = avs_write && !waitReq_reg && avs_byteenable[0];
  assign wrKey   = wrAcc && idx == IDX_KEY;
  assign wrCtrl  = wrAcc && idx == IDX_CTRL;
  assign wrTaddr = wrAcc && idx == IDX_TADDR;
  assign wrTdata = wrAcc && idx == IDX_TDATA;
  assign wrIclr  = wrAcc && idx == IDX_ICLR;
  assign wrIen   = wrAcc && idx == IDX_IEN;

  function automatic logic [31:0] regRead(input logic [7:0] i);
    logic [31:0] r;
    r = '0;
    case (i)
      IDX_KEY:   r = {30'h0, key_reg}; // RULE_15
      IDX_CTRL:  r = {27'h0, fail_reg, seq_reg == SEQ_RUN, 1'b0, eraseSel_reg, progSel_reg}; // RULE_09
      IDX_TADDR: r = {18'h0, tAddr_reg};
      IDX_TDATA: r = {24'h0, tgt_reg.data};
      IDX_ISTAT: r = {29'h0, stat_reg};
      IDX_IEN:   r = {29'h0, ien_reg};
      default:   r = '0;
    endcase
    return r;
  endfunction : regRead

  // one wait cycle on every access; unmapped reads give zero
  always_comb begin
    waitReq_next = !((avs_read || avs_write) && waitReq_reg);
    rdData_next  = rdData_reg;
    if (avs_read && waitReq_reg) begin
      rdData_next = regRead(idx);
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      waitReq_reg <= 1'b1;
      rdData_reg  <= '0;
    end else if (clkEn) begin
      waitReq_reg <= waitReq_next;
      rdData_reg  <= rdData_next;
    end
  end

  fpeu_op_timer #(
    .CW (TMR_W)
  ) u_timer (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .clkEn   (clkEn),
    .start   (tmrStart),
    .load    (tmrLoad),
    .done    (tmrDone)
  );

  always_comb begin
    key_next      = key_reg;
    seq_next      = seq_reg;
    progSel_next  = progSel_reg;
    eraseSel_next = eraseSel_reg;
    fail_next     = fail_reg;
    tAddr_next    = tAddr_reg;
    tgt_next      = tgt_reg;
    cmd_next      = cmd_reg;
    pStb_next     = 1'b0;
    eStb_next     = 1'b0;
    tmrStart      = 1'b0;
    tmrLoad       = '0;
    ev            = '0;
    ien_next      = ien_reg;
    rstReq_next   = fetchUnprot && accessProt; // RULE_08

    // key sequence; a frozen lock only leaves by reset
    if (wrKey) begin
      case (key_reg)
        KEY_LOCKED: key_next = (wd == KEY_FIRST)  ? KEY_HALF     : KEY_FROZEN; // RULE_12
        KEY_HALF:   key_next = (wd == KEY_SECOND) ? KEY_RELEASED : KEY_FROZEN; // RULE_12
        KEY_FROZEN: key_next = KEY_FROZEN; // RULE_13
        default:    key_next = key_reg;
      endcase
    end

    if (wrTaddr) begin
      tAddr_next = avs_writedata[FLASH_AW-1:0];
    end

    // external-space write into flash only counts while released
    if (wrTdata && key_reg == KEY_RELEASED && seq_reg == SEQ_IDLE) begin
      tgt_next.addr  = tAddr_reg; // RULE_18
      tgt_next.data  = wd;
      tgt_next.valid = 1'b1;
    end

    // control writes during an operation are dropped to keep the target stable
    if (wrCtrl && seq_reg == SEQ_IDLE) begin
      progSel_next  = wd[CTRL_PROG];
      eraseSel_next = wd[CTRL_ERAS];
      fail_next     = wd[CTRL_FAIL];
      if (key_reg == KEY_RELEASED) begin
        // RULE_10 RULE_11 RULE_17
        if (wd[CTRL_TRIG] && wd[CTRL_PROG] && tgt_reg.valid) begin
          if (fpeuLastSector(tgt_reg.addr)) begin
            fail_next      = 1'b1; // RULE_02 RULE_03
            ev[EV_FAIL]    = 1'b1;
            ev[EV_DONE]    = 1'b1;
            key_next       = KEY_LOCKED; // RULE_06
            tgt_next.valid = 1'b0;
          end else begin
            seq_next       = SEQ_RUN;
            cmd_next.addr  = tgt_reg.addr; // RULE_18
            cmd_next.data  = tgt_reg.data;
            cmd_next.erase = wd[CTRL_ERAS]; // RULE_11
            pStb_next      = !wd[CTRL_ERAS];
            eStb_next      = wd[CTRL_ERAS];
            tmrStart       = 1'b1;
            tmrLoad        = wd[CTRL_ERAS] ? ERASE_CYCLES : PROG_CYCLES; // RULE_07
          end
        end else begin
          key_next       = KEY_LOCKED; // RULE_14
          tgt_next.valid = 1'b0;
        end
      end
    end

    if (seq_reg == SEQ_RUN && tmrDone) begin
      seq_next       = SEQ_IDLE;
      fail_next      = flashMacroFail; // RULE_09
      key_next       = KEY_LOCKED; // RULE_06
      tgt_next.valid = 1'b0;
      ev[EV_DONE]    = 1'b1;
      ev[EV_FAIL]    = flashMacroFail;
    end

    ev[EV_FROZEN] = key_next == KEY_FROZEN && key_reg != KEY_FROZEN;

    // a new event wins over a clear in the same cycle
    stat_next = (stat_reg & ~(wrIclr ? avs_writedata[EV_W-1:0] : '0)) | ev;
    if (wrIen) begin
      ien_next = avs_writedata[EV_W-1:0];
    end
    irq_next = |(stat_next & ien_next);
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      key_reg      <= KEY_LOCKED;
      seq_reg      <= SEQ_IDLE;
      progSel_reg  <= CTRL_RST[CTRL_PROG];
      eraseSel_reg <= CTRL_RST[CTRL_ERAS];
      fail_reg     <= CTRL_RST[CTRL_FAIL];
      tAddr_reg    <= '0;
      tgt_reg      <= '0;
      cmd_reg      <= '0;
      pStb_reg     <= 1'b0;
      eStb_reg     <= 1'b0;
      rstReq_reg   <= 1'b0;
      stat_reg     <= '0;
      ien_reg      <= '0;
      irq_reg      <= 1'b0;
    end else if (clkEn) begin
      key_reg      <= key_next;
      seq_reg      <= seq_next;
      progSel_reg  <= progSel_next;
      eraseSel_reg <= eraseSel_next;
      fail_reg     <= fail_next;
      tAddr_reg    <= tAddr_next;
      tgt_reg      <= tgt_next;
      cmd_reg      <= cmd_next;
      pStb_reg     <= pStb_next;
      eStb_reg     <= eStb_next;
      rstReq_reg   <= rstReq_next;
      stat_reg     <= stat_next;
      ien_reg      <= ien_next;
      irq_reg      <= irq_next;
    end
  end

  assign avs_readdata     = rdData_reg;
  assign avs_waitrequest  = waitReq_reg;
  assign flashCmd         = cmd_reg;
  assign flashProgStrobe  = pStb_reg;
  assign flashEraseStrobe = eStb_reg;
  assign chipResetReq     = rstReq_reg;
  assign irq              = irq_reg;

  // checks are suspended while the clock enable freezes the block
  property p_no_last_erase;
    @(posedge mclk) disable iff (sys_rst || !clkEn)
      eStb_reg |-> !fpeuLastSector(cmd_reg.addr);
  endproperty
  a_no_last_erase: assert property (p_no_last_erase) // RULE_03
    else $error("erase strobe aimed at last sector");

  property p_no_last_prog;
    @(posedge mclk) disable iff (sys_rst || !clkEn)
      (pStb_reg || eStb_reg) |-> cmd_reg.addr[FLASH_AW-1:SECTOR_AW] != LAST_SECTOR;
  endproperty
  a_no_last_prog: assert property (p_no_last_prog) // RULE_02
    else $error("operation started in last sector");

  property p_frozen_sticks;
    @(posedge mclk) disable iff (sys_rst || !clkEn)
      key_reg == KEY_FROZEN |=> key_reg == KEY_FROZEN;
  endproperty
  a_frozen_sticks: assert property (p_frozen_sticks) // RULE_13
    else $error("lock left frozen state without reset");

  property p_release_from_half;
    @(posedge mclk) disable iff (sys_rst || !clkEn)
      (key_reg == KEY_RELEASED && $past(key_reg) != KEY_RELEASED)
        |-> $past(key_reg) == KEY_HALF && $past(wd) == KEY_SECOND;
  endproperty
  a_release_from_half: assert property (p_release_from_half) // RULE_12
    else $error("lock released without key pair");

  property p_relock_after_op;
    @(posedge mclk) disable iff (sys_rst || !clkEn)
      (seq_reg == SEQ_RUN && tmrDone) |=> key_reg == KEY_LOCKED && seq_reg == SEQ_IDLE;
  endproperty
  a_relock_after_op: assert property (p_relock_after_op) // RULE_06
    else $error("lock not restored after operation");

  property p_fail_result;
    @(posedge mclk) disable iff (sys_rst || !clkEn)
      (seq_reg == SEQ_RUN && tmrDone) |=> fail_reg == $past(flashMacroFail);
  endproperty
  a_fail_result: assert property (p_fail_result) // RULE_09
    else $error("fail flag does not match operation result");

  property p_erase_duration;
    @(posedge mclk) disable iff (sys_rst || !clkEn)
      eStb_reg |-> seq_reg == SEQ_RUN [*8];
  endproperty
  a_erase_duration: assert property (p_erase_duration) // RULE_07
    else $error("erase finished far too early");

  property p_trig_zero_idle;
    @(posedge mclk) disable iff (sys_rst || !clkEn)
      (wrCtrl && !wd[CTRL_TRIG]) |=> !pStb_reg && !eStb_reg;
  endproperty
  a_trig_zero_idle: assert property (p_trig_zero_idle) // RULE_10
    else $error("operation started without trigger");

  property p_erase_needs_prog;
    @(posedge mclk) disable iff (sys_rst || !clkEn)
      (wrCtrl && !wd[CTRL_PROG]) |=> !eStb_reg && !pStb_reg;
  endproperty
  a_erase_needs_prog: assert property (p_erase_needs_prog) // RULE_11
    else $error("erase started without program select");

  property p_start_needs_release;
    @(posedge mclk) disable iff (sys_rst || !clkEn)
      (pStb_reg || eStb_reg) |-> $past(key_reg) == KEY_RELEASED;
  endproperty
  a_start_needs_release: assert property (p_start_needs_release) // RULE_17
    else $error("operation started while not released");

  property p_ctrl_relocks;
    @(posedge mclk) disable iff (sys_rst || !clkEn)
      (wrCtrl && key_reg == KEY_RELEASED && seq_reg == SEQ_IDLE && !wd[CTRL_TRIG])
        |=> key_reg == KEY_LOCKED;
  endproperty
  a_ctrl_relocks: assert property (p_ctrl_relocks) // RULE_14
    else $error("control write did not relock");

  property p_key_read;
    @(posedge mclk) disable iff (sys_rst || !clkEn)
      (avs_read && waitReq_reg && idx == IDX_KEY)
        |=> avs_readdata[31:2] == '0 && avs_readdata[1:0] == $past(key_reg);
  endproperty
  a_key_read: assert property (p_key_read) // RULE_15
    else $error("key read value wrong");

  property p_target_used;
    @(posedge mclk) disable iff (sys_rst || !clkEn)
      (pStb_reg || eStb_reg) |-> cmd_reg.addr == $past(tgt_reg.addr);
  endproperty
  a_target_used: assert property (p_target_used) // RULE_18
    else $error("operation target differs from captured write");

  property p_reset_req;
    @(posedge mclk) disable iff (sys_rst || !clkEn)
      (fetchUnprot && accessProt) |=> chipResetReq;
  endproperty
  a_reset_req: assert property (p_reset_req) // RULE_08
    else $error("protected access did not request reset");

  c_erase_start: cover property (@(posedge mclk) disable iff (sys_rst) eStb_reg);
  c_prog_start:  cover property (@(posedge mclk) disable iff (sys_rst) pStb_reg);
  c_frozen:      cover property (@(posedge mclk) disable iff (sys_rst) key_reg == KEY_FROZEN);
  c_irq:         cover property (@(posedge mclk) disable iff (sys_rst) irq_reg);

endmodule : fpeu_top

// file: core/fpeu_pkg.sv
// constants, types and helpers shared by the flash sequencer files
// Notes on behaviour
// RULE_01: flash is 128 sectors of 128 bytes
// RULE_02: only first 127 sectors take program/erase
// RULE_03: last sector is never erased
// RULE_04: erase: control 0x03, key, target write, trigger
// RULE_05: program: control 0x01, key, data write, trigger
// RULE_06: lock returns to locked after each operation
// RULE_07: sector erase lasts about 120 to 150 ms
// RULE_08: unprotected fetch touching protected area resets chip
// RULE_09: fail flag bit 4 shows last operation result
// RULE_10: trigger bit 3 starts operation; zero does nothing
// RULE_11: erase select works only with program select
// RULE_12: keys 0x5a then 0x1f release the lock
// RULE_13: wrong key freezes lock until next reset
// RULE_14: control write while released relocks the lock
// RULE_15: key read: zeros above two-bit lock state
// RULE_16: software disables interrupts before any sequence
// RULE_17: trigger ignored unless lock is released
// RULE_18: target write captured while released, used by trigger
package fpeu_pkg;

  // flash geometry
  localparam int FLASH_AW    = 14;
  localparam int SECTOR_AW   = 7;
  localparam int SECTOR_NUMW = FLASH_AW - SECTOR_AW;
  localparam logic [SECTOR_NUMW-1:0] LAST_SECTOR = 7'h7f;

  // register indices, byte address is four times the index
  localparam logic [7:0] IDX_KEY   = 8'h84;
  localparam logic [7:0] IDX_CTRL  = 8'h85;
  localparam logic [7:0] IDX_TADDR = 8'h86;
  localparam logic [7:0] IDX_TDATA = 8'h87;
  localparam logic [7:0] IDX_ISTAT = 8'h88;
  localparam logic [7:0] IDX_ICLR  = 8'h89;
  localparam logic [7:0] IDX_IEN   = 8'h8a;
  localparam int         AV_AW     = 10;

  // control register fields
  localparam int CTRL_PROG = 0;
  localparam int CTRL_ERAS = 1;
  localparam int CTRL_TRIG = 3;
  localparam int CTRL_FAIL = 4;
  localparam logic [7:0] CMD_PROG_SEQ = 8'h01;
  localparam logic [7:0] CMD_ERAS_SEQ = 8'h03;

  // key values and reset values
  localparam logic [7:0] KEY_FIRST  = 8'h5a;
  localparam logic [7:0] KEY_SECOND = 8'h1f;
  localparam logic [7:0] KEY_RST    = 8'h00;
  localparam logic [7:0] CTRL_RST   = 8'h00;

  // interrupt event bits
  localparam int EV_DONE   = 0;
  localparam int EV_FAIL   = 1;
  localparam int EV_FROZEN = 2;
  localparam int EV_W      = 3;

  // timing
  localparam int             TMR_W             = 32;
  localparam longint         CLK_HZ            = 40_000_000;
  localparam longint         ERASE_TIME_MS     = 120;
  localparam longint         ERASE_CYCLES_DFLT = (ERASE_TIME_MS * CLK_HZ + 999) / 1000;
  localparam int unsigned    PROG_CYCLES_DFLT  = 40;

  typedef enum logic [1:0] {KEY_LOCKED, KEY_HALF, KEY_FROZEN, KEY_RELEASED} fpeu_key_e;
  typedef enum logic {SEQ_IDLE, SEQ_RUN} fpeu_seq_e;

  typedef struct packed {
    logic [FLASH_AW-1:0] addr;
    logic [7:0]          data;
    logic                erase;
  } fpeu_cmd_s;

  typedef struct packed {
    logic [FLASH_AW-1:0] addr;
    logic [7:0]          data;
    logic                valid;
  } fpeu_tgt_s;

  function automatic logic fpeuLastSector(input logic [FLASH_AW-1:0] a);
    return a[FLASH_AW-1:SECTOR_AW] == LAST_SECTOR; // RULE_01
  endfunction : fpeuLastSector

endpackage : fpeu_pkg

// file: core/fpeu_op_timer.sv
// operation duration counter for program and erase
`timescale 1ns/1ps
module fpeu_op_timer import fpeu_pkg::*; #(
  parameter int CW = TMR_W
) (
  // clock and reset
  input  wire logic          mclk,
  input  wire logic          sys_rst,
  input  wire logic          clkEn,
  // control
  input  wire logic          start,
  input  wire logic [CW-1:0] load,
  // status
  output logic               done
);

  if (CW < 2 || CW > 32) begin : g_bad_width
    $error("fpeu_op_timer: CW out of range");
  end

  logic [CW-1:0] cnt_reg, cnt_next;
  logic          run_reg, run_next;
  logic          done_reg, done_next;

  always_comb begin
    cnt_next  = cnt_reg;
    run_next  = run_reg;
    done_next = 1'b0;
    if (start) begin
      cnt_next = load;
      run_next = 1'b1;
    end else if (run_reg) begin
      if (cnt_reg <= CW'(1)) begin
        run_next  = 1'b0;
        done_next = 1'b1;
      end else begin
        cnt_next = cnt_reg - CW'(1);
      end
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_reg  <= '0;
      run_reg  <= 1'b0;
      done_reg <= 1'b0;
    end else if (clkEn) begin
      cnt_reg  <= cnt_next;
      run_reg  <= run_next;
      done_reg <= done_next;
    end
  end

  assign done = done_reg;

endmodule : fpeu_op_timer

// file: tb/tb_flash_program_erase_unlock.sv
// self-checking bench for the flash program/erase sequencer
`timescale 1ns/1ps
module tb_flash_program_erase_unlock import fpeu_pkg::*; ();
  localparam int unsigned ERASE_N = 20;
  localparam int unsigned PROG_N  = 3;

  // clock, reset and bus
  logic             mclk;
  logic             sys_rst;
  logic [AV_AW-1:0] avsAddress;
  logic             avsRead;
  logic             avsWrite;
  logic [31:0]      avsWritedata;
  logic [3:0]       avsByteenable;
  logic [31:0]      avsReaddata;
  logic             avsWaitrequest;
  // flash macro, protection, interrupt
  fpeu_cmd_s        flashCmd;
  logic             flashProgStrobe;
  logic             flashEraseStrobe;
  logic             flashMacroFail;
  logic             fetchUnprot;
  logic             accessProt;
  logic             chipResetReq;
  logic             irq;
  // bookkeeping
  int               miscompares;
  int               tests_run;
  int               progCnt;
  int               eraseCnt;
  fpeu_cmd_s        lastCmd;
  logic [31:0]      q;

  // short counts keep erase runs cheap
  fpeu_top #(.ERASE_CYCLES(ERASE_N), .PROG_CYCLES(PROG_N)) uut (
    .mclk(mclk), .sys_rst(sys_rst), .clkEn(1'b1),
    .avs_address(avsAddress), .avs_read(avsRead), .avs_write(avsWrite),
    .avs_writedata(avsWritedata), .avs_byteenable(avsByteenable),
    .avs_readdata(avsReaddata), .avs_waitrequest(avsWaitrequest),
    .flashCmd(flashCmd), .flashProgStrobe(flashProgStrobe),
    .flashEraseStrobe(flashEraseStrobe), .flashMacroFail(flashMacroFail),
    .fetchUnprot(fetchUnprot), .accessProt(accessProt),
    .chipResetReq(chipResetReq), .irq(irq));

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  // strobes are one-cycle pulses, so count them at every edge
  always @(posedge mclk) begin
    if (flashProgStrobe === 1'b1) begin
      progCnt++;
      lastCmd = flashCmd;
    end
    if (flashEraseStrobe === 1'b1) begin
      eraseCnt++;
      lastCmd = flashCmd;
    end
  end

  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict

  task automatic chkVal(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chkVal

  task automatic chkBit(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chkBit

  task automatic ranOut();
    miscompares++;
    $display("BAD t=%0t wait ran out got %h exp %h", $time, 1'b1, 1'b0);
    give_verdict();
  endtask : ranOut

  // avalon access: hold everything until waitrequest is sampled low
  task automatic avXfer(input logic wr, input logic [7:0] idx, input logic [31:0] d,
                        input logic [3:0] be, output logic [31:0] rq);
    int n;
    @(posedge mclk);
    avsAddress    <= {idx, 2'b00};
    avsWrite      <= wr;
    avsRead       <= ~wr;
    avsWritedata  <= d;
    avsByteenable <= be;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (avsWaitrequest !== 1'b0 && n < 100);
    if (avsWaitrequest !== 1'b0) ranOut();
    rq = avsReaddata;
    avsWrite <= 1'b0;
    avsRead  <= 1'b0;
  endtask : avXfer

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] dummy;
    avXfer(1'b1, idx, d, 4'hf, dummy);
  endtask : wr

  task automatic rdReg(input logic [7:0] idx, output logic [31:0] rq);
    avXfer(1'b0, idx, 32'h0, 4'hf, rq);
  endtask : rdReg

  task automatic resetDut();
    @(posedge mclk);
    sys_rst <= 1'b1;
    repeat (3) @(posedge mclk);
    sys_rst <= 1'b0;
  endtask : resetDut

  // full unlock, target, trigger sequence, then poll busy and check outcome
  task automatic doOp(input logic [7:0] sel, input logic [13:0] a, input logic [7:0] dat,
                      input logic fl);
    int p0;
    int e0;
    int n;
    logic last;
    logic go;
    p0   = progCnt;
    e0   = eraseCnt;
    last = (a[13:7] == 7'h7f);
    go   = sel[0];
    flashMacroFail <= fl;
    wr(IDX_CTRL, {24'h0, sel});
    wr(IDX_KEY, {24'h0, KEY_FIRST});
    rdReg(IDX_KEY, q);
    chkVal(q, 32'h1);
    wr(IDX_KEY, {24'h0, KEY_SECOND});
    rdReg(IDX_KEY, q);
    chkVal(q, 32'h3);
    wr(IDX_TADDR, {18'h0, a});
    wr(IDX_TDATA, {24'h0, dat});
    rdReg(IDX_TDATA, q);
    chkVal(q, {24'h0, dat});
    wr(IDX_CTRL, {24'h0, sel | 8'h08});
    n = 0;
    do begin
      rdReg(IDX_CTRL, q);
      n++;
    end while (q[3] !== 1'b0 && n < 200);
    if (q[3] !== 1'b0) ranOut();
    chkVal(32'(progCnt - p0), 32'(go && !last && !sel[1]));
    chkVal(32'(eraseCnt - e0), 32'(go && !last && sel[1]));
    if (go && !last) chkVal(32'(lastCmd), 32'({a, dat, sel[1]}));
    chkBit(q[4], go & (last | fl));
    rdReg(IDX_KEY, q);
    chkVal(q, 32'h0);
  endtask : doOp

  initial begin
    int i;
    int k;
    logic [7:0] sel;
    logic f;
    logic g;
    logic [7:0] selTab [3];
    selTab = '{8'h01, 8'h03, 8'h02};
    sys_rst = 1'b1;
    avsAddress = '0;
    avsRead = 1'b0;
    avsWrite = 1'b0;
    avsWritedata = '0;
    avsByteenable = 4'hf;
    flashMacroFail = 1'b0;
    fetchUnprot = 1'b0;
    accessProt = 1'b0;
    miscompares = 0;
    tests_run = 0;
    progCnt = 0;
    eraseCnt = 0;
    void'($urandom(32'hb77abb70));
    resetDut();
    rdReg(IDX_KEY, q);
    chkVal(q, 32'h0);
    rdReg(IDX_CTRL, q);
    chkVal(q, 32'h0);
    rdReg(8'h90, q);
    chkVal(q, 32'h0);
    // boundary targets around the protected top sector
    doOp(8'h03, 14'h3f7f, 8'h00, 1'b0);
    doOp(8'h03, 14'h3f80, 8'h00, 1'b0);
    doOp(8'h01, 14'h3fff, 8'h5c, 1'b0);
    doOp(8'h01, 14'h0000, 8'hff, 1'b1);
    for (i = 0; i < 12; i++) begin
      sel = selTab[$urandom % 3];
      if ($urandom % 4 == 0)
        doOp(sel, {7'h7f, 7'($urandom)}, 8'($urandom), 1'($urandom));
      else
        doOp(sel, {7'($urandom % 127), 7'($urandom)}, 8'($urandom), 1'($urandom));
    end
    // trigger while locked must not start anything
    k = progCnt;
    wr(IDX_TADDR, 32'h40);
    wr(IDX_TDATA, 32'h33);
    wr(IDX_CTRL, 32'h09);
    repeat (PROG_N + 4) @(posedge mclk);
    chkVal(32'(progCnt - k), 32'h0);
    // released, target captured, control written with trigger zero
    wr(IDX_KEY, {24'h0, KEY_FIRST});
    wr(IDX_KEY, {24'h0, KEY_SECOND});
    wr(IDX_TDATA, 32'h33);
    wr(IDX_CTRL, 32'h11);
    repeat (PROG_N + 4) @(posedge mclk);
    chkVal(32'(progCnt - k), 32'h0);
    rdReg(IDX_KEY, q);
    chkVal(q, 32'h0);
    // fail bit is software-writable while idle
    rdReg(IDX_CTRL, q);
    chkVal(q, 32'h11);
    // interrupt raise, mask, clear
    wr(IDX_ICLR, 32'h7);
    wr(IDX_IEN, 32'h3);
    doOp(8'h01, 14'h0100, 8'ha5, 1'b1);
    rdReg(IDX_ISTAT, q);
    chkVal(q, 32'h3);
    repeat (2) @(posedge mclk);
    chkBit(irq, 1'b1);
    wr(IDX_IEN, 32'h4);
    rdReg(IDX_IEN, q);
    chkVal(q, 32'h4);
    repeat (2) @(posedge mclk);
    chkBit(irq, 1'b0);
    wr(IDX_IEN, 32'h1);
    repeat (2) @(posedge mclk);
    chkBit(irq, 1'b1);
    wr(IDX_ICLR, 32'h3);
    rdReg(IDX_ISTAT, q);
    chkVal(q, 32'h0);
    repeat (2) @(posedge mclk);
    chkBit(irq, 1'b0);
    rdReg(IDX_ICLR, q);
    chkVal(q, 32'h0);
    // write without low byte enable is ignored
    avXfer(1'b1, IDX_TADDR, 32'h1234, 4'he, q);
    rdReg(IDX_TADDR, q);
    chkVal(q, 32'h100);
    wr(8'h90, 32'hff);
    rdReg(8'h90, q);
    chkVal(q, 32'h0);
    // illegal access detection, random combinations
    for (i = 0; i < 8; i++) begin
      f = 1'($urandom);
      g = (i == 0) ? 1'b1 : 1'($urandom);
      @(posedge mclk);
      fetchUnprot <= f | (i == 0);
      accessProt  <= g;
      @(posedge mclk);
      @(posedge mclk);
      chkBit(chipResetReq, (f | (i == 0)) & g);
    end
    fetchUnprot <= 1'b0;
    accessProt  <= 1'b0;
    // bad key sequences freeze until reset
    for (k = 0; k < 3; k++) begin
      resetDut();
      wr(IDX_KEY, (k == 0) ? 32'h1f : 32'h5a);
      if (k > 0) wr(IDX_KEY, (k == 1) ? 32'h5a : 32'h77);
      wr(IDX_KEY, {24'h0, KEY_FIRST});
      wr(IDX_KEY, {24'h0, KEY_SECOND});
      rdReg(IDX_KEY, q);
      chkVal(q, 32'h2);
      rdReg(IDX_ISTAT, q);
      chkBit(q[EV_FROZEN], 1'b1);
      i = progCnt;
      wr(IDX_TDATA, 32'h11);
      wr(IDX_CTRL, 32'h09);
      repeat (PROG_N + 4) @(posedge mclk);
      chkVal(32'(progCnt - i), 32'h0);
    end
    resetDut();
    rdReg(IDX_KEY, q);
    chkVal(q, 32'h0);
    give_verdict();
  end
endmodule : tb_flash_program_erase_unlock
